// >>> dv/fecs_flash_model.sv
// Behavioural flash device: erase command decoding, status and busy line
module fecs_flash_model
  import fecs_pkg::*;
#(
  parameter int WIN   = 40,
  parameter int ERASE = 300
)(
  input  wire logic          clk_in,
  input  wire logic          ce_n_in,
  input  wire logic          we_n_in,
  input  wire logic          oe_n_in,
  input  wire logic          reset_n_in,
  input  wire logic [AW-1:0] addr_in,
  input  wire logic [DW-1:0] dq_in,
  output logic      [DW-1:0] dq_out,
  output logic               ready_busy_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [AW-1:0] log_a [0:63];
  logic [DW-1:0] log_d [0:63];
  logic [DW-1:0] rd_w;
  logic [DW-1:0] last = '0;
  logic [1:0]    st = 2'd0;
  logic          chip = 1'b0;
  logic          tog = 1'b0;
  int            nw = 0;
  int            nrd = 0;
  int            step = 0;
  int            cnt = 0;
  // State: 0 read, 1 accept window, 2 erasing, 3 suspended
  always @(posedge we_n_in)
  begin
    if (!ce_n_in && reset_n_in)
    begin
      log_a[nw] = addr_in;
      log_d[nw] = dq_in;
      nw++;
      if (st == 2'd0 && step < 5)
        step = (addr_in == ((step == 1 || step == 4) ? UNLOCK2_ADDR : UNLOCK1_ADDR) &&
                dq_in == ((step == 2) ? D_SETUP : (step == 1 || step == 4) ? D_UNLOCK2 :
                D_UNLOCK1)) ? step + 1 : 0;
      else if (st == 2'd0)
      begin
        step = 0;
        chip = (dq_in == D_CHIP && addr_in == UNLOCK1_ADDR);
        if (chip || dq_in == D_SECTOR)
        begin
          st = chip ? 2'd2 : 2'd1;
          cnt = chip ? ERASE : WIN;
        end
      end
      else if (st == 2'd1)
      begin
        st = (dq_in == D_SECTOR) ? 2'd1 : (dq_in == D_SUSPEND) ? 2'd3 : 2'd0;
        cnt = WIN;
      end
      else if (st == 2'd2 && !chip && dq_in == D_SUSPEND)
        st = 2'd3;
      else if (st == 2'd3 && dq_in == D_RESUME)
        st = 2'd2;
    end
  end
  // Off the sampling edge, so the busy line never races the design
  always @(negedge clk_in)
  begin
    if (!reset_n_in)
    begin
      st = 2'd0;
      step = 0;
    end
    else if (st == 2'd1 || st == 2'd2)
    begin
      if (cnt > 0)
        cnt--;
      else if (st == 2'd1)
      begin
        st = 2'd2;
        cnt = ERASE;
      end
      else
        st = 2'd0;
    end
  end
  always @(negedge oe_n_in) tog = ~tog;
  always @(posedge oe_n_in)
  begin
    last = rd_w;
    nrd++;
  end
  assign ready_busy_n_out = !(st == 2'd1 || st == 2'd2);
  // Status replaces array data at every address in the accept window, erasing or suspended
  assign rd_w = (st == 2'd0) ? (addr_in[15:0] ^ 16'h5a5a) :
                {8'h00, st == 2'd3, (st == 2'd3) ? 1'b0 : tog, 2'b00, st >= 2'd2, tog,
                 2'b00};
  // Released bus shows the inverse so a stale sample cannot pass
  assign dq_out = (!ce_n_in && !oe_n_in) ? rd_w : ~last;
endmodule

// >>> dv/fecs_top_monitor.sv
// Port-level checker for the flash erase command sequencer
module fecs_top_monitor
  import fecs_pkg::*;
#(
  parameter int PH_CYC  = 20,
  parameter int RST_CYC = 125
)(
  input wire logic          CLK_IN,
  input wire logic          RESETN_IN,
  input wire logic          HREADYOUT_OUT,
  input wire logic          HRESP_OUT,
  input wire logic [AW-1:0] FL_ADDR_OUT,
  input wire logic [DW-1:0] FL_DQ_OUT,
  input wire logic          FL_DQ_OE_OUT,
  input wire logic          FL_CE_N_OUT,
  input wire logic          FL_WE_N_OUT,
  input wire logic          FL_OE_N_OUT,
  input wire logic          FL_RESET_N_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  int we_cnt;
  int ce_cnt;
  int rs_cnt;
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  // Low-phase lengths, read at the edge where the strobe is back high
  always_ff @(posedge CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      we_cnt <= 0;
      ce_cnt <= 0;
      rs_cnt <= 0;
    end
    else
    begin
      we_cnt <= FL_WE_N_OUT ? 0 : we_cnt + 1;
      ce_cnt <= FL_CE_N_OUT ? 0 : ce_cnt + 1;
      rs_cnt <= FL_RESET_N_OUT ? 0 : rs_cnt + 1;
    end
  end
  a_resp_okay: assert property (HRESP_OUT == 1'b0)
    else $error("slave response not OKAY");
  a_zero_wait: assert property ($past(RESETN_IN) |-> HREADYOUT_OUT)
    else $error("slave inserted a wait state");
  a_we_in_ce: assert property (!FL_WE_N_OUT |-> !FL_CE_N_OUT && FL_DQ_OE_OUT && FL_OE_N_OUT)
    else $error("write strobe outside a driven chip-select");
  a_we_width: assert property ($rose(FL_WE_N_OUT) |-> we_cnt == PH_CYC)
    else $error("write strobe low time wrong");
  a_ce_length: assert property ($rose(FL_CE_N_OUT) |-> ce_cnt == 3 * PH_CYC ##1 FL_CE_N_OUT)
    else $error("flash cycle length wrong");
  a_wr_held: assert property (!FL_CE_N_OUT && $past(!FL_CE_N_OUT) && FL_DQ_OE_OUT
                              |-> $stable(FL_ADDR_OUT) && $stable(FL_DQ_OUT))
    else $error("address or data moved inside a write");
  a_rst_width: assert property ($rose(FL_RESET_N_OUT) |-> rs_cnt == RST_CYC)
    else $error("hardware reset pulse length wrong");
  a_rst_quiet: assert property (!FL_RESET_N_OUT |-> FL_CE_N_OUT && FL_WE_N_OUT)
    else $error("bus cycle during hardware reset");
  a_read_float: assert property (!FL_OE_N_OUT |-> !FL_DQ_OE_OUT && FL_WE_N_OUT)
    else $error("data driven during a read");
endmodule

bind fecs_top fecs_top_monitor #(.PH_CYC(PH_CYC), .RST_CYC(RST_CYC)) i_fecs_top_monitor (
  .CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN), .HREADYOUT_OUT(HREADYOUT_OUT),
  .HRESP_OUT(HRESP_OUT), .FL_ADDR_OUT(FL_ADDR_OUT), .FL_DQ_OUT(FL_DQ_OUT),
  .FL_DQ_OE_OUT(FL_DQ_OE_OUT), .FL_CE_N_OUT(FL_CE_N_OUT), .FL_WE_N_OUT(FL_WE_N_OUT),
  .FL_OE_N_OUT(FL_OE_N_OUT), .FL_RESET_N_OUT(FL_RESET_N_OUT));

// >>> dv/fecs_top_tb_top.sv
// Self-checking testbench for the flash erase command sequencer
module fecs_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fecs_pkg::*;
  localparam logic [AW-1:0] SA1 = 21'h010000;
  localparam logic [AW-1:0] SA2 = 21'h020000;
  logic          clk = 1'b0;
  logic          rst_n = 1'b0;
  logic          hsel = 1'b0;
  logic [31:0]   haddr = '0;
  logic [1:0]    htrans = 2'h0;
  logic          hwrite = 1'b0;
  logic [31:0]   hwdata = '0;
  logic [31:0]   hrdata;
  logic          hready;
  logic          hresp;
  logic [AW-1:0] fl_addr;
  logic [DW-1:0] fl_dq_out;
  logic [DW-1:0] mdl_dq;
  logic [DW-1:0] fl_dq;
  logic          fl_oe;
  logic          ce_n;
  logic          we_n;
  logic          oe_n;
  logic          frst_n;
  logic          rb_n;
  int            num_errors = 0;
  int            compares = 0;
  always #2 clk = ~clk;
  assign fl_dq = fl_oe ? fl_dq_out : mdl_dq;
  fecs_top #(.PH_CYC(3), .RST_CYC(4), .WIN_LIMIT(40), .SUSP_WAIT(20)) i_fecs_top (
    .CLK_IN(clk), .RESETN_IN(rst_n), .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans),
    .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HREADY_IN(hready), .HWDATA_IN(hwdata),
    .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .FL_ADDR_OUT(fl_addr),
    .FL_DQ_IN(fl_dq), .FL_DQ_OUT(fl_dq_out), .FL_DQ_OE_OUT(fl_oe), .FL_CE_N_OUT(ce_n),
    .FL_WE_N_OUT(we_n), .FL_OE_N_OUT(oe_n), .FL_RESET_N_OUT(frst_n),
    .FL_READY_BUSY_N_IN(rb_n));
  fecs_flash_model u_flash (
    .clk_in(clk), .ce_n_in(ce_n), .we_n_in(we_n), .oe_n_in(oe_n), .reset_n_in(frst_n),
    .addr_in(fl_addr), .dq_in(fl_dq), .dq_out(mdl_dq), .ready_busy_n_out(rb_n));
  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_wr(input int i, input logic [AW-1:0] a, input logic [DW-1:0] d);
    compares++;
    if (u_flash.log_a[i] !== a || u_flash.log_d[i] !== d)
    begin
      num_errors++;
      $display("MISMATCH flash write %0d expected %h/%h seen %h/%h", i, a, d,
               u_flash.log_a[i], u_flash.log_d[i]);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk);
    haddr <= {24'h000000, a};
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask
  task automatic st_is(input logic [31:0] m, input logic [31:0] e);
    logic [31:0] s;
    ahb(1'b0, REG_STAT, 32'h0, s);
    chk("status", e, s & m);
  endtask
  task automatic cmd(input logic [3:0] c, input logic [AW-1:0] a);
    wr(REG_ADDR, {11'h000, a});
    wr(REG_CMD, {28'h0000000, c});
  endtask
  // Next command only once the link is idle again, else it would be refused
  task automatic wait_bus(input int n, input bit rdc);
    int k;
    for (k = 0; k < 2000 && !(((rdc ? u_flash.nrd : u_flash.nw) >= n) && ce_n === 1'b1); k++)
      @(posedge clk);
    if (k == 2000)
      chk("flash cycles", n, rdc ? u_flash.nrd : u_flash.nw);
    repeat (6) @(posedge clk);
  endtask
  task automatic wait_mode(input logic [2:0] m, input int lim);
    logic [31:0] s;
    int k;
    s = {28'h0, ~m, 1'b0};
    for (k = 0; k < lim && s[3:1] !== m; k++)
      ahb(1'b0, REG_STAT, 32'h0, s);
    chk("mode", {29'h0, m}, {29'h0, s[3:1]});
  endtask
  task automatic chk_seq(input int b, input logic [AW-1:0] a, input logic [DW-1:0] d);
    for (int i = 0; i < 5; i++)
      chk_wr(b + i, (i == 1 || i == 4) ? UNLOCK2_ADDR : UNLOCK1_ADDR,
             (i == 2) ? D_SETUP : (i == 1 || i == 4) ? D_UNLOCK2 : D_UNLOCK1);
    chk_wr(b + 5, a, d);
  endtask
  initial
  begin
    logic [31:0] r;
    int b;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    st_is(32'h0000_0fff, 32'h0000_0040);
    ahb(1'b0, 8'h10, 32'h0, r);
    chk("unmapped", 32'h0, r);
    wr(REG_ADDR, 32'hffff_ffff);
    ahb(1'b0, REG_ADDR, 32'h0, r);
    chk("address register", 32'h001f_ffff, r);
    wr(REG_CMD, {28'h0, CMD_ADD});
    st_is(32'h0000_001e, 32'h0000_0010);
    $display("test registers done");
    b = u_flash.nw;
    cmd(CMD_CHIP, 21'h0);
    wait_bus(b + 6, 1'b0);
    chk_seq(b, UNLOCK1_ADDR, D_CHIP);
    cmd(CMD_SUSP, SA1);
    st_is(32'h0000_005e, 32'h0000_0016);
    chk("writes in chip erase", b + 6, u_flash.nw);
    wait_mode(3'd0, 500);
    cmd(CMD_POLL, 21'h000123);
    wait_bus(u_flash.nrd + 1, 1'b1);
    ahb(1'b0, REG_POLL, 32'h0, r);
    chk("polled word", 32'h0000_5b79, r);
    st_is(32'h0000_0f00, 32'h0000_0a00);
    $display("test chip erase done");
    b = u_flash.nw;
    cmd(CMD_SECT, SA1);
    wait_bus(b + 6, 1'b0);
    chk_seq(b, SA1, D_SECTOR);
    cmd(CMD_ADD, SA2);
    wait_bus(b + 7, 1'b0);
    chk_wr(b + 6, SA2, D_SECTOR);
    wait_mode(3'd2, 100);
    st_is(32'h0000_003e, 32'h0000_0024);
    cmd(CMD_SUSP, SA2);
    wait_mode(3'd5, 20);
    wait_bus(b + 8, 1'b0);
    chk_wr(b + 7, SA2, D_SUSPEND);
    cmd(CMD_RESUME, SA2);
    wait_bus(b + 9, 1'b0);
    chk_wr(b + 8, SA2, D_RESUME);
    cmd(CMD_RESUME, SA2);
    st_is(32'h0000_001e, 32'h0000_0014);
    chk("repeated resume", b + 9, u_flash.nw);
    wait_mode(3'd0, 500);
    $display("test sector erase done");
    b = u_flash.nw;
    cmd(CMD_SECT, SA1);
    wait_bus(b + 6, 1'b0);
    cmd(CMD_SUSP, SA1);
    wait_mode(3'd5, 6);
    wait_bus(b + 7, 1'b0);
    cmd(CMD_RESET, SA1);
    wait_bus(b + 8, 1'b0);
    st_is(32'h0000_001e, 32'h0000_000a);
    chk("flash suspended", 32'h3, {30'h0, u_flash.st});
    cmd(CMD_RESUME, SA1);
    wait_mode(3'd0, 500);
    $display("test window suspend done");
    b = u_flash.nw;
    cmd(CMD_SECT, SA1);
    wait_bus(b + 6, 1'b0);
    cmd(CMD_RESET, SA1);
    wait_bus(b + 7, 1'b0);
    chk_wr(b + 6, SA1, D_RESET);
    wait_mode(3'd0, 6);
    chk("flash read state", 32'h0, {30'h0, u_flash.st});
    b = u_flash.nw;
    cmd(CMD_CHIP, 21'h0);
    wait_bus(b + 6, 1'b0);
    cmd(CMD_HWRST, 21'h0);
    wait_mode(3'd0, 20);
    chk("flash aborted", 32'h0, {30'h0, u_flash.st});
    $display("test resets done");
    stop_test();
  end
  initial
  begin
    repeat (40000) @(posedge clk);
    num_errors++;
    $display("MISMATCH run length expected finish seen timeout");
    stop_test();
  end
endmodule

// >>> logic/fecs_ahb_slave.sv
// AHB-Lite slave front end: zero wait state, always OKAY
module fecs_ahb_slave
  import fecs_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic        hready_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic [31:0] rd_word_in,
  output logic      [7:0]  ap_off_out,
  output logic             ap_ok_out,
  output logic             wr_en_out,
  output logic      [7:0]  wr_off_out,
  output logic      [31:0] wr_data_out,
  output logic      [31:0] hrdata_out
);
  logic ap_take;
  logic wr_pend_q;
  assign ap_take     = hsel_in && hready_in && htrans_in[1];
  assign ap_off_out  = haddr_in[7:0];
  assign ap_ok_out   = (haddr_in[31:8] == 24'h000000) && (haddr_in[1:0] == 2'h0);
  assign wr_en_out   = wr_pend_q;
  assign wr_data_out = hwdata_in;
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      wr_pend_q  <= 1'b0;
      wr_off_out <= 8'h00;
      hrdata_out <= 32'h00000000;
    end
    else
    begin
      wr_pend_q <= ap_take && hwrite_in && ap_ok_out;
      if (ap_take)
      begin
        wr_off_out <= ap_off_out;
        // Read data is ready at the start of the data phase
        hrdata_out <= (!hwrite_in && ap_ok_out) ? rd_word_in : 32'h00000000;
      end
    end
  end
endmodule

// >>> logic/fecs_flash_cycle.sv
// One asynchronous flash bus cycle, write or read, built from clock phases
module fecs_flash_cycle
  import fecs_pkg::*;
#(
  parameter int PH_CYC = 20
)(
  input  wire logic            clk_in,
  input  wire logic            rst_n_in,
  input  wire logic            start_in,
  input  wire fecs_pkg::fecs_req_t req_in,
  input  wire logic [DW-1:0]   dq_pin_in,
  output fecs_pkg::fecs_pins_t pins_out,
  output logic                 we_rise_out,
  output logic                 done_out,
  output logic      [DW-1:0]   rdata_out
);
  typedef enum {P_IDLE, P_SETUP, P_STROBE, P_HOLD} fecs_ph_t;
  fecs_ph_t         ph_q;
  logic [15:0]      cnt_q;
  logic             rd_q;
  logic [DW-1:0]    dq_s1_q;
  logic [DW-1:0]    dq_s2_q;
  logic             ph_end;
  assign ph_end = (cnt_q == 16'(PH_CYC - 1));
  always_ff @(posedge clk_in)
  begin
    dq_s1_q <= dq_pin_in;
    dq_s2_q <= dq_s1_q;
  end
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      ph_q        <= P_IDLE;
      cnt_q       <= 16'h0000;
      rd_q        <= 1'b0;
      pins_out    <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, default: '0};
      we_rise_out <= 1'b0;
      done_out    <= 1'b0;
      rdata_out   <= '0;
    end
    else
    begin
      we_rise_out <= 1'b0;
      done_out    <= 1'b0;
      cnt_q       <= ph_end ? 16'h0000 : cnt_q + 16'h0001;
      case (ph_q)
        P_IDLE:
        begin
          cnt_q <= 16'h0000;
          if (start_in)
          begin
            ph_q          <= P_SETUP;
            rd_q          <= req_in.rd;
            pins_out.ce_n <= 1'b0;
            pins_out.oe_n <= !req_in.rd;
            pins_out.addr <= req_in.addr;
            pins_out.dq   <= req_in.data;
            pins_out.dq_oe <= !req_in.rd;
          end
        end
        P_SETUP:
          if (ph_end)
          begin
            ph_q          <= P_STROBE;
            pins_out.we_n <= rd_q;
          end
        P_STROBE:
          if (ph_end)
          begin
            ph_q          <= P_HOLD;
            pins_out.we_n <= 1'b1;
            we_rise_out   <= !rd_q;
          end
        P_HOLD:
          if (ph_end)
          begin
            // Sampled late so the two sync stages have settled
            if (rd_q)
              rdata_out <= dq_s2_q;
            ph_q           <= P_IDLE;
            done_out       <= 1'b1;
            pins_out.ce_n  <= 1'b1;
            pins_out.oe_n  <= 1'b1;
            pins_out.dq_oe <= 1'b0;
          end
        default:
          ph_q <= P_IDLE;
      endcase
    end
  end
endmodule

// >>> logic/fecs_pkg.sv
// Shared constants and carrier types for the flash erase command sequencer
package fecs_pkg;
  localparam int AW = 21;
  localparam int DW = 16;
  localparam logic [AW-1:0] UNLOCK1_ADDR = 21'h000555;
  localparam logic [AW-1:0] UNLOCK2_ADDR = 21'h0002aa;
  localparam logic [DW-1:0] D_UNLOCK1 = 16'h00aa;
  localparam logic [DW-1:0] D_UNLOCK2 = 16'h0055;
  localparam logic [DW-1:0] D_SETUP   = 16'h0080;
  localparam logic [DW-1:0] D_CHIP    = 16'h0010;
  localparam logic [DW-1:0] D_SECTOR  = 16'h0030;
  localparam logic [DW-1:0] D_SUSPEND = 16'h00b0;
  localparam logic [DW-1:0] D_RESUME  = 16'h0030;
  localparam logic [DW-1:0] D_RESET   = 16'h00f0;
  // Register offsets of the controller
  localparam logic [7:0] REG_CMD  = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_POLL = 8'h0c;
  // Command codes written to REG_CMD[3:0]
  localparam logic [3:0] CMD_CHIP   = 4'h1;
  localparam logic [3:0] CMD_SECT   = 4'h2;
  localparam logic [3:0] CMD_ADD    = 4'h3;
  localparam logic [3:0] CMD_SUSP   = 4'h4;
  localparam logic [3:0] CMD_RESUME = 4'h5;
  localparam logic [3:0] CMD_RESET  = 4'h6;
  localparam logic [3:0] CMD_HWRST  = 4'h7;
  localparam logic [3:0] CMD_POLL   = 4'h8;
  localparam logic [2:0] LAST_LONG  = 3'h5;
  // Status register bit positions
  localparam int ST_BUSY    = 0;
  localparam int ST_MODE    = 1;
  localparam int ST_REFUSED = 4;
  localparam int ST_LAPSED  = 5;
  localparam int ST_RB      = 6;
  localparam int ST_POLL7   = 8;
  localparam int ST_TOG6    = 9;
  localparam int ST_TOG2    = 10;
  localparam int ST_WIN3    = 11;
  // Flash status bit positions in a polled word
  localparam int DQ_POLL = 7;
  localparam int DQ_TOG  = 6;
  localparam int DQ_WIN  = 3;
  localparam int DQ_ALT  = 2;
  // Timing
  localparam int CLK_MHZ      = 250;
  localparam int WIN_TIME_US  = 50;
  localparam int SUSP_TIME_US = 20;
  localparam int WIN_CYC      = WIN_TIME_US * CLK_MHZ;
  localparam int SUSP_CYC     = SUSP_TIME_US * CLK_MHZ;
  typedef struct packed {
    logic          rd;
    logic [AW-1:0] addr;
    logic [DW-1:0] data;
  } fecs_req_t;
  typedef struct packed {
    logic          ce_n;
    logic          we_n;
    logic          oe_n;
    logic [AW-1:0] addr;
    logic [DW-1:0] dq;
    logic          dq_oe;
  } fecs_pins_t;
endpackage

// >>> logic/fecs_top.sv
// Host-side erase command sequencer driving a parallel flash
module fecs_top
  import fecs_pkg::*;
#(
  parameter int PH_CYC    = 20,
  parameter int RST_CYC   = 125,
  parameter int WIN_LIMIT = WIN_CYC,
  parameter int SUSP_WAIT = SUSP_CYC
)(
  input  wire logic          CLK_IN,
  input  wire logic          RESETN_IN,
  input  wire logic          HSEL_IN,
  input  wire logic [31:0]   HADDR_IN,
  input  wire logic [1:0]    HTRANS_IN,
  input  wire logic          HWRITE_IN,
  input  wire logic [2:0]    HSIZE_IN,
  input  wire logic          HREADY_IN,
  input  wire logic [31:0]   HWDATA_IN,
  output logic      [31:0]   HRDATA_OUT,
  output logic               HREADYOUT_OUT,
  output logic               HRESP_OUT,
  output logic      [AW-1:0] FL_ADDR_OUT,
  input  wire logic [DW-1:0] FL_DQ_IN,
  output logic      [DW-1:0] FL_DQ_OUT,
  output logic               FL_DQ_OE_OUT,
  output logic               FL_CE_N_OUT,
  output logic               FL_WE_N_OUT,
  output logic               FL_OE_N_OUT,
  output logic               FL_RESET_N_OUT,
  input  wire logic          FL_READY_BUSY_N_IN
);
  import fecs_pkg::*;

  typedef enum {S_IDLE, S_ISSUE, S_WAIT, S_RST} fecs_seq_t;
  typedef enum logic [2:0] {
    M_READ, M_WINDOW, M_ERASE, M_CHIP, M_SUSPENDING, M_SUSP
  } fecs_mode_t;

  fecs_seq_t     seq_q;
  fecs_seq_t     seq_d;
  fecs_mode_t    mode_q;
  fecs_mode_t    mode_d;
  logic [3:0]    cmd_q;
  logic [2:0]    step_q;
  logic [AW-1:0] addr_q;
  logic [15:0]   tmr_q;
  logic [15:0]   rst_cnt_q;
  logic          refused_q;
  logic          lapsed_q;
  logic [DW-1:0] poll_q;
  logic          rb_s1_q;
  logic          rb_s2_q;
  logic          rb_s3_q;
  logic          start_q;

  logic [7:0]    ap_off;
  logic          ap_ok;
  logic          wr_en;
  logic [7:0]    wr_off;
  logic [31:0]   wr_data;
  logic [31:0]   rd_word;
  logic [31:0]   stat_word;
  fecs_req_t     req;
  fecs_pins_t    pins;
  logic          we_rise;
  logic          cyc_done;
  logic [DW-1:0] cyc_rdata;
  logic          cmd_wr;
  logic          accept;
  logic          last_step;
  logic          final_rise;
  logic          rb_rise;
  logic          tmr_win_end;
  logic          tmr_susp_end;
  logic          rst_end;

  // Sequence table: the host writes the exact expected pattern, except for poll, which reads
  function automatic fecs_req_t fecs_step(input logic [3:0] cmd,
                                          input logic [2:0] idx,
                                          input logic [AW-1:0] sa);
    fecs_req_t r;
    r = '{rd: 1'b0, addr: sa, data: D_RESET};
    case (cmd)
      CMD_CHIP, CMD_SECT:
        case (idx)
          3'h0, 3'h3: r = '{rd: 1'b0, addr: UNLOCK1_ADDR, data: D_UNLOCK1};
          3'h1, 3'h4: r = '{rd: 1'b0, addr: UNLOCK2_ADDR, data: D_UNLOCK2};
          3'h2:       r = '{rd: 1'b0, addr: UNLOCK1_ADDR, data: D_SETUP};
          default:
            r = (cmd == CMD_CHIP) ? '{rd: 1'b0, addr: UNLOCK1_ADDR, data: D_CHIP}
                                  : '{rd: 1'b0, addr: sa, data: D_SECTOR};
        endcase
      CMD_ADD:    r = '{rd: 1'b0, addr: sa, data: D_SECTOR};
      CMD_SUSP:   r = '{rd: 1'b0, addr: sa, data: D_SUSPEND};
      CMD_RESUME: r = '{rd: 1'b0, addr: sa, data: D_RESUME};
      CMD_POLL:   r = '{rd: 1'b1, addr: sa, data: '0};
      default:    r = '{rd: 1'b0, addr: sa, data: D_RESET};
    endcase
    return r;
  endfunction

  // Which orders the flash would act on in its present mode
  function automatic logic fecs_allowed(input logic [3:0] cmd, input fecs_mode_t m);
    logic ok;
    ok = 1'b0;
    case (cmd)
      CMD_POLL, CMD_HWRST: ok = 1'b1;
      CMD_CHIP, CMD_SECT:  ok = (m == M_READ);
      CMD_ADD:             ok = (m == M_WINDOW);
      CMD_SUSP:            ok = (m == M_WINDOW) || (m == M_ERASE);
      CMD_RESUME:          ok = (m == M_SUSP);
      CMD_RESET:           ok = (m == M_READ) || (m == M_WINDOW) || (m == M_SUSP);
      default:             ok = 1'b0;
    endcase
    return ok;
  endfunction

  fecs_ahb_slave u_ahb (
    .clk_in      (CLK_IN),
    .rst_n_in    (RESETN_IN),
    .hsel_in     (HSEL_IN),
    .haddr_in    (HADDR_IN),
    .htrans_in   (HTRANS_IN),
    .hwrite_in   (HWRITE_IN),
    .hready_in   (HREADY_IN),
    .hwdata_in   (HWDATA_IN),
    .rd_word_in  (rd_word),
    .ap_off_out  (ap_off),
    .ap_ok_out   (ap_ok),
    .wr_en_out   (wr_en),
    .wr_off_out  (wr_off),
    .wr_data_out (wr_data),
    .hrdata_out  (HRDATA_OUT)
  );

  fecs_flash_cycle #(
    .PH_CYC (PH_CYC)
  ) u_cyc (
    .clk_in      (CLK_IN),
    .rst_n_in    (RESETN_IN),
    .start_in    (start_q),
    .req_in      (req),
    .dq_pin_in   (FL_DQ_IN),
    .pins_out    (pins),
    .we_rise_out (we_rise),
    .done_out    (cyc_done),
    .rdata_out   (cyc_rdata)
  );

  assign FL_ADDR_OUT  = pins.addr;
  assign FL_DQ_OUT    = pins.dq;
  assign FL_DQ_OE_OUT = pins.dq_oe;
  assign FL_CE_N_OUT  = pins.ce_n;
  assign FL_WE_N_OUT  = pins.we_n;
  assign FL_OE_N_OUT  = pins.oe_n;

  assign req          = fecs_step(cmd_q, step_q, addr_q);
  assign cmd_wr       = wr_en && (wr_off == REG_CMD);
  assign accept       = cmd_wr && (seq_q == S_IDLE) && fecs_allowed(wr_data[3:0], mode_q);
  assign last_step    = ((cmd_q == CMD_CHIP) || (cmd_q == CMD_SECT)) ? (step_q == LAST_LONG)
                                                                   : (step_q == 3'h0);
  assign final_rise   = we_rise && last_step;
  assign rb_rise      = rb_s2_q && !rb_s3_q;
  assign tmr_win_end  = (tmr_q == 16'(WIN_LIMIT - 1));
  assign tmr_susp_end = (tmr_q == 16'(SUSP_WAIT - 1));
  assign rst_end      = (rst_cnt_q == 16'(RST_CYC - 1));

  assign stat_word = {20'h00000,
                      poll_q[DQ_WIN], poll_q[DQ_ALT], poll_q[DQ_TOG], poll_q[DQ_POLL],
                      1'b0, rb_s2_q, lapsed_q, refused_q,
                      mode_q, (seq_q != S_IDLE)};
  assign rd_word = !ap_ok               ? 32'h00000000 :
                   (ap_off == REG_ADDR) ? 32'(addr_q) :
                   (ap_off == REG_STAT) ? stat_word :
                   (ap_off == REG_POLL) ? 32'(poll_q) : 32'h00000000;

  always_comb
  begin
    seq_d = seq_q;
    case (seq_q)
      S_IDLE:
        if (accept)
          seq_d = (wr_data[3:0] == CMD_HWRST) ? S_RST : S_ISSUE;
      S_ISSUE:
        seq_d = S_WAIT;
      S_WAIT:
        if (cyc_done)
          seq_d = last_step ? S_IDLE : S_ISSUE;
      S_RST:
        if (rst_end)
          seq_d = S_IDLE;
      default:
        seq_d = S_IDLE;
    endcase
  end

  // Mode tracks what the flash is doing, so illegal orders never reach the pins
  always_comb
  begin
    mode_d = mode_q;
    case (mode_q)
      M_WINDOW:
        if (tmr_win_end)
          mode_d = M_ERASE;
      M_ERASE, M_CHIP:
        if (rb_rise)
          mode_d = M_READ;
      M_SUSPENDING:
        if (tmr_susp_end)
          mode_d = M_SUSP;
      default:
        mode_d = mode_q;
    endcase
    if (final_rise)
      case (cmd_q)
        CMD_CHIP:   mode_d = M_CHIP;
        CMD_SECT,
        CMD_ADD:    mode_d = M_WINDOW;
        CMD_SUSP:   mode_d = (mode_q == M_WINDOW) ? M_SUSP : M_SUSPENDING;
        CMD_RESUME: mode_d = M_ERASE;
        CMD_RESET:  mode_d = (mode_q == M_SUSP) ? M_SUSP : M_READ;
        default:    mode_d = mode_d;
      endcase
    // Suspended mode survives a reset command; only the hardware reset pulse returns it to read
    if (seq_q == S_RST)
      mode_d = M_READ;
  end

  always_ff @(posedge CLK_IN)
  begin
    rb_s1_q <= FL_READY_BUSY_N_IN;
    rb_s2_q <= rb_s1_q;
    rb_s3_q <= rb_s2_q;
  end

  always_ff @(posedge CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      seq_q  <= S_IDLE;
      mode_q <= M_READ;
      cmd_q  <= 4'h0;
      step_q <= 3'h0;
      start_q <= 1'b0;
    end
    else
    begin
      seq_q   <= seq_d;
      mode_q  <= mode_d;
      start_q <= (seq_d == S_ISSUE);
      if (accept)
      begin
        cmd_q  <= wr_data[3:0];
        step_q <= 3'h0;
      end
      else if (cyc_done && !last_step)
        step_q <= step_q + 3'h1;
    end
  end

  // Window and suspend timers share one counter; they never overlap
  always_ff @(posedge CLK_IN)
  begin
    if (!RESETN_IN)
      tmr_q <= 16'h0000;
    else if (final_rise)
      tmr_q <= 16'h0000;
    else if ((mode_q == M_WINDOW) || (mode_q == M_SUSPENDING))
      tmr_q <= tmr_q + 16'h0001;
  end

  always_ff @(posedge CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      addr_q    <= '0;
      refused_q <= 1'b0;
      lapsed_q  <= 1'b0;
      poll_q    <= '0;
    end
    else
    begin
      if (wr_en && (wr_off == REG_ADDR) && (seq_q == S_IDLE))
        addr_q <= wr_data[AW-1:0];
      if (cmd_wr)
        refused_q <= !accept;
      if (final_rise && (cmd_q == CMD_SECT))
        lapsed_q <= 1'b0;
      else if ((mode_q == M_WINDOW) && tmr_win_end)
        lapsed_q <= 1'b1;
      if (cyc_done && (cmd_q == CMD_POLL))
        poll_q <= cyc_rdata;
    end
  end

  // Hardware reset pulse: the sequence must be rerun by software afterwards
  always_ff @(posedge CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      rst_cnt_q      <= 16'h0000;
      FL_RESET_N_OUT <= 1'b1;
    end
    else
    begin
      FL_RESET_N_OUT <= !(seq_d == S_RST);
      rst_cnt_q      <= (seq_q == S_RST) ? rst_cnt_q + 16'h0001 : 16'h0000;
    end
  end

  always_ff @(posedge CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      HREADYOUT_OUT <= 1'b0;
      HRESP_OUT     <= 1'b0;
    end
    else
    begin
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT     <= 1'b0;
    end
  end
endmodule
